// [core/uiopm_pkg.sv]
// Purpose: constants and carriers for the io and power management register bank
// Assumes: register port of the transceiver's register access engine, 8-bit data
// Notes:   offsets are the immediate register addresses
package uiopm_pkg;

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [5:0] IOPWR_WR_ADDR  = 6'h39;
    localparam logic [5:0] IOPWR_SET_ADDR = 6'h3A;
    localparam logic [5:0] IOPWR_CLR_ADDR = 6'h3B;
    localparam logic [5:0] RID_WR_ADDR    = 6'h36;
    localparam logic [5:0] RID_SET_ADDR   = 6'h37;
    localparam logic [5:0] RID_CLR_ADDR   = 6'h38;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int         SWAP_BIT       = 1;
    localparam int         UART_LVL_LSB   = 2;
    localparam int         PU_PLUS_BIT    = 4;
    localparam int         PU_MINUS_BIT   = 5;
    localparam int         USB_LVL_LSB    = 6;
    localparam logic [7:0] IOPWR_WMASK    = 8'hFE;
    localparam logic [7:0] IOPWR_RESET    = 8'h04;
    localparam int         RID_CODE_LSB   = 0;
    localparam int         RID_DONE_BIT   = 3;
    localparam int         RID_GO_BIT     = 4;
    localparam int         RID_IEN_BIT    = 6;
    localparam logic [7:0] RID_WMASK      = 8'h50;
    localparam logic [7:0] RID_RESET      = 8'h00;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int         CLK_HZ         = 40_000_000;
    localparam int         MEAS_TIME_US   = 282;
    localparam int         MEAS_CYCLES    = (MEAS_TIME_US * (CLK_HZ / 1_000_000));

    // ----------------------------------------
    // regulator level codes
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        UIOPM_LVL_3V3  = 2'b00,
        UIOPM_LVL_3V0  = 2'b01,
        UIOPM_LVL_2V75 = 2'b10,
        UIOPM_LVL_2V5  = 2'b11
    } uiopm_lvl_t;

    // register access request from the register engine
    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } uiopm_req_t;

    // analogue controls towards the pads and regulator
    typedef struct packed
    {
        logic       pin_pair_swap;
        logic       charger_pullup_plus_line;
        logic       charger_pullup_minus_line;
        uiopm_lvl_t regulator_level;
        logic       id_meas_running;
    } uiopm_ana_t;

endpackage

// [core/uiopm_regs.sv]
// Purpose: io and power management register with id resistance measurement control
// Assumes: one clock, register requests from the ulpi register engine on the same clock
// Notes:   analogue status inputs arrive from outside the clock domain and are synchronised
`timescale 1ns/10ps

// Function
// [RL1] reads at three addresses; write replaces, set ors, clear removes bits
// [RL2] bit 1 swaps plus and minus pin functions, usb and uart; resets zero
// [RL3] bits 3:2 select uart regulator level; reset value 01
// [RL4] usb to uart switch applies uart level once transmit drive enabled
// [RL5] bits 4 and 5 enable plus and minus charger pull-ups; reset zero
// [RL6] uart mode forces both charger pull-ups on
// [RL7] bits 7:6 select usb regulator level; reset value 00
// [RL8] synchronous, serial or low power mode use usb level
// [RL9] link waits id grounded, enables pull-up, starts, waits done, reads code
// [RL10] bit 0 reserved: reads zero, writes ignored
// [RL11] measurement takes 282 us, then done sets and start clears
// [RL12] id resistance reported as three-bit code
// [RL13] registers reached by ordinary immediate register reads and writes
module uiopm_regs
#(
    parameter int MEAS_CYCLES = uiopm_pkg::MEAS_CYCLES
)
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    // register access
    input  wire uiopm_pkg::uiopm_req_t reg_req,
    output logic [7:0]                reg_rdata,
    output logic                      reg_hit,
    // operating mode
    input  wire logic                 uart_mode,
    input  wire logic                 transmit_line_drive_enable,
    // id measurement analogue
    input  wire logic                 id_conv_ready_async,
    input  wire logic [2:0]           id_conv_code_async,
    // analogue controls
    output uiopm_pkg::uiopm_ana_t     ana_ctl,
    output logic                      rid_alt_int
);

    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end
        else
        begin
            sync1_r <= {id_conv_ready_async, id_conv_code_async};
            sync2_r <= sync1_r;
        end
    end

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic io_wr;
    logic io_set;
    logic io_clr;
    logic rid_wr;
    logic rid_set;
    logic rid_clr;
    logic io_rd;
    logic rid_rd;

    // [RL13] immediate access decode
    assign io_wr   = reg_req.wr && (reg_req.addr == uiopm_pkg::IOPWR_WR_ADDR);
    assign io_set  = reg_req.wr && (reg_req.addr == uiopm_pkg::IOPWR_SET_ADDR);
    assign io_clr  = reg_req.wr && (reg_req.addr == uiopm_pkg::IOPWR_CLR_ADDR);
    assign rid_wr  = reg_req.wr && (reg_req.addr == uiopm_pkg::RID_WR_ADDR);
    assign rid_set = reg_req.wr && (reg_req.addr == uiopm_pkg::RID_SET_ADDR);
    assign rid_clr = reg_req.wr && (reg_req.addr == uiopm_pkg::RID_CLR_ADDR);
    assign io_rd   = (reg_req.addr >= uiopm_pkg::IOPWR_WR_ADDR) && (reg_req.addr <= uiopm_pkg::IOPWR_CLR_ADDR);
    assign rid_rd  = (reg_req.addr >= uiopm_pkg::RID_WR_ADDR) && (reg_req.addr <= uiopm_pkg::RID_CLR_ADDR);

    // ----------------------------------------
    // io and power management register
    // ----------------------------------------
    logic [7:0] iopwr_r;
    logic [7:0] iopwr_nxt;

    always_comb
    begin
        iopwr_nxt = iopwr_r;
        // [RL1] write, set, clear
        if (io_wr)
            iopwr_nxt = reg_req.wdata;
        else if (io_set)
            iopwr_nxt = iopwr_r | reg_req.wdata;
        else if (io_clr)
            iopwr_nxt = iopwr_r & ~reg_req.wdata;
        // [RL10] reserved bit held zero
        iopwr_nxt = iopwr_nxt & uiopm_pkg::IOPWR_WMASK;
    end

    // [RL3] [RL7] reset levels
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            iopwr_r <= uiopm_pkg::IOPWR_RESET;
        else
            iopwr_r <= iopwr_nxt;
    end

    // ----------------------------------------
    // id resistance measurement register
    // ----------------------------------------
    localparam int CW = $clog2(MEAS_CYCLES + 1);

    logic [7:0]    rid_r;
    logic [7:0]    rid_nxt;
    logic [CW-1:0] meas_cnt_r;
    logic          meas_end;
    logic          done_clr;

    // [RL11] fixed measurement time
    assign meas_end = rid_r[uiopm_pkg::RID_GO_BIT] && (meas_cnt_r == CW'(MEAS_CYCLES - 1));
    assign done_clr = reg_req.rd && rid_rd;

    always_comb
    begin
        rid_nxt = rid_r & ~uiopm_pkg::RID_WMASK;
        if (rid_wr)
            rid_nxt = rid_nxt | (reg_req.wdata & uiopm_pkg::RID_WMASK);
        else if (rid_set)
            rid_nxt = rid_nxt | ((rid_r | reg_req.wdata) & uiopm_pkg::RID_WMASK);
        else if (rid_clr)
            rid_nxt = rid_nxt | ((rid_r & ~reg_req.wdata) & uiopm_pkg::RID_WMASK);
        else
            rid_nxt = rid_r;
        // read clears done; a finishing measurement wins
        if (done_clr)
            rid_nxt[uiopm_pkg::RID_DONE_BIT] = 1'b0;
        // [RL11] done sets, start clears
        if (meas_end)
        begin
            rid_nxt[uiopm_pkg::RID_DONE_BIT] = 1'b1;
            rid_nxt[uiopm_pkg::RID_GO_BIT]   = 1'b0;
            // [RL12] capture code
            rid_nxt[2:0] = sync2_r[3] ? sync2_r[2:0] : 3'b111;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rid_r <= uiopm_pkg::RID_RESET;
        else
            rid_r <= rid_nxt;
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            meas_cnt_r <= '0;
        else if (!rid_r[uiopm_pkg::RID_GO_BIT] || meas_end)
            meas_cnt_r <= '0;
        else
            meas_cnt_r <= meas_cnt_r + CW'(1);
    end

    // ----------------------------------------
    // regulator level selection
    // ----------------------------------------
    logic uart_level_r;

    // [RL4] uart level after transmit drive enable
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            uart_level_r <= 1'b0;
        else if (!uart_mode)
            uart_level_r <= 1'b0;
        else if (transmit_line_drive_enable)
            uart_level_r <= 1'b1;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    uiopm_pkg::uiopm_ana_t ana_r;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ana_r <= '0;
        end
        else
        begin
            // [RL2] pin pair swap
            ana_r.pin_pair_swap             <= iopwr_r[uiopm_pkg::SWAP_BIT];
            // [RL5] [RL6] charger pull-ups
            ana_r.charger_pullup_plus_line  <= iopwr_r[uiopm_pkg::PU_PLUS_BIT] | uart_mode;
            ana_r.charger_pullup_minus_line <= iopwr_r[uiopm_pkg::PU_MINUS_BIT] | uart_mode;
            // [RL8] [RL4] regulator level
            ana_r.regulator_level           <= (uart_level_r && uart_mode)
                ? uiopm_pkg::uiopm_lvl_t'(iopwr_r[uiopm_pkg::UART_LVL_LSB +: 2])
                : uiopm_pkg::uiopm_lvl_t'(iopwr_r[uiopm_pkg::USB_LVL_LSB +: 2]);
            ana_r.id_meas_running           <= rid_r[uiopm_pkg::RID_GO_BIT];
        end
    end

    assign ana_ctl     = ana_r;
    assign rid_alt_int = rid_r[uiopm_pkg::RID_DONE_BIT] & rid_r[uiopm_pkg::RID_IEN_BIT];

    // [RL1] read data, [RL10] reserved reads zero
    always_comb
    begin
        reg_hit   = io_rd || rid_rd;
        reg_rdata = 8'h00;
        if (io_rd)
            reg_rdata = iopwr_r;
        else if (rid_rd)
            reg_rdata = rid_r;
    end

endmodule

// [bench/uiopm_conv_model.sv]
// Purpose: id resistance comparator model
// Assumes: runs while the block measures
// Notes:   code toggles while idle
`timescale 1ns/10ps
module uiopm_conv_model
(
    // clock
    input  wire logic       sys_clk,
    // control
    input  wire logic       running,
    input  wire logic       present,
    input  wire logic [2:0] code_in,
    // comparator
    output logic            ready,
    output logic [2:0]      code
);
    initial code = 3'h0;
    always @(posedge sys_clk)
    begin
        ready <= running & present;
        code  <= running ? code_in : ~code;
    end
endmodule

// [bench/uiopm_regs_checker.sv]
// Purpose: assertions on the io power register
// Assumes: short measurement in sim
// Notes:   bind after the module
`timescale 1ns/10ps
module uiopm_regs_checker
#(
    parameter int MEAS_CYCLES = uiopm_pkg::MEAS_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register access
    input wire uiopm_pkg::uiopm_req_t reg_req,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  reg_hit,
    // mode and analogue
    input wire logic                  uart_mode,
    input wire logic                  transmit_line_drive_enable,
    input wire logic                  id_conv_ready_async,
    input wire logic [2:0]            id_conv_code_async,
    input wire uiopm_pkg::uiopm_ana_t ana_ctl,
    input wire logic                  rid_alt_int
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic        io;
    logic [15:0] run_cnt;
    assign io = reg_req.addr inside {6'h39, 6'h3A, 6'h3B};
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            run_cnt <= 16'h0000;
        else
            run_cnt <= ana_ctl.id_meas_running ? run_cnt + 16'h0001 : 16'h0000;
    end
    sequence wr_at(a);
        reg_req.wr && reg_req.addr == a ##1 io;
    endsequence
    sequence uart_tx_seen;
        uart_mode && transmit_line_drive_enable ##1 uart_mode && io;
    endsequence
    chk_bit0_zero: assert property (io |-> !reg_rdata[0])
        else $error("reserved bit set");
    chk_write_load: assert property (wr_at(6'h39) |-> reg_rdata == ($past(reg_req.wdata) & 8'hFE))
        else $error("write wrong");
    chk_set_bits: assert property (wr_at(6'h3A) |->
        reg_rdata == ($past(reg_rdata) | ($past(reg_req.wdata) & 8'hFE)))
        else $error("set wrong");
    chk_clear_bits: assert property (wr_at(6'h3B) |->
        reg_rdata == ($past(reg_rdata) & ~$past(reg_req.wdata)))
        else $error("clear wrong");
    chk_swap_out: assert property (io |=> ana_ctl.pin_pair_swap == |($past(reg_rdata) & 8'h02))
        else $error("swap wrong");
    chk_pullup_out: assert property (io |=>
        ana_ctl.charger_pullup_plus_line == (|($past(reg_rdata) & 8'h10) || $past(uart_mode)) &&
        ana_ctl.charger_pullup_minus_line == (|($past(reg_rdata) & 8'h20) || $past(uart_mode)))
        else $error("pull-up wrong");
    chk_usb_level: assert property (io && !uart_mode |=>
        8'(ana_ctl.regulator_level) == ($past(reg_rdata) >> 6))
        else $error("usb level wrong");
    chk_uart_level: assert property (uart_tx_seen |=>
        8'(ana_ctl.regulator_level) == (($past(reg_rdata) >> 2) & 8'h03))
        else $error("uart level wrong");
    chk_meas_bound: assert property (ana_ctl.id_meas_running |-> run_cnt < MEAS_CYCLES + 4)
        else $error("measurement too long");
endmodule
bind uiopm_regs uiopm_regs_checker #(.MEAS_CYCLES(MEAS_CYCLES)) i_uiopm_regs_checker (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .uart_mode(uart_mode),
    .transmit_line_drive_enable(transmit_line_drive_enable), .id_conv_ready_async(id_conv_ready_async),
    .id_conv_code_async(id_conv_code_async), .ana_ctl(ana_ctl), .rid_alt_int(rid_alt_int));

// [bench/tb.sv]
// Purpose: self-checking bench for the io power register
// Assumes: 40 MHz clock, short measurement
// Notes:   inputs change 2 ns after the edge
`timescale 1ns/10ps
module tb;
    localparam int         MC = 20;
    logic                  sys_clk;
    logic                  sys_rst;
    uiopm_pkg::uiopm_req_t req;
    logic [7:0]            rdata;
    logic                  hit;
    logic                  uart_mode;
    logic                  txen;
    logic                  ready;
    logic [2:0]            code;
    uiopm_pkg::uiopm_ana_t ana;
    logic                  alt;
    logic                  present;
    logic [2:0]            code_sel;
    int                    error_cnt;
    int                    total_checks;
    uiopm_regs #(.MEAS_CYCLES(MC)) i_uiopm_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(req),
        .reg_rdata(rdata), .reg_hit(hit), .uart_mode(uart_mode), .transmit_line_drive_enable(txen),
        .id_conv_ready_async(ready), .id_conv_code_async(code), .ana_ctl(ana), .rid_alt_int(alt));
    uiopm_conv_model i_uiopm_conv_model (.sys_clk(sys_clk), .running(ana.id_meas_running),
        .present(present), .code_in(code_sel), .ready(ready), .code(code));
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        cyc(1);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        cyc(1);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        cyc(1);
        req.rd   = 1'b1;
        req.addr = a;
        #1;
        chk(rdata, exp);
        cyc(1);
        req.rd = 1'b0;
    endtask
    task automatic t_access();
        rd(6'h3B, 8'h04);
        wr(6'h39, 8'hFF);
        rd(6'h3A, 8'hFE);
        chk({2'b00, ana}, 8'h3E);
        wr(6'h3B, 8'hC2);
        rd(6'h39, 8'h3C);
        chk({7'h00, hit}, 8'h01);
        wr(6'h3A, 8'h41);
        wr(6'h30, 8'hFF);
        rd(6'h30, 8'h00);
        chk({7'h00, hit}, 8'h00);
        rd(6'h3B, 8'h7C);
        chk({2'b00, ana}, 8'h1A);
    endtask
    task automatic t_levels();
        for (int i = 0; i < 4; i++)
        begin
            wr(6'h39, 8'(i << 6));
            cyc(1);
            chk({6'h00, ana.regulator_level}, 8'(i));
        end
    endtask
    task automatic t_uart();
        wr(6'h39, 8'h08);
        uart_mode = 1'b1;
        cyc(2);
        chk({2'b00, ana}, 8'h18);
        txen = 1'b1;
        cyc(2);
        txen = 1'b0;
        cyc(2);
        chk({6'h00, ana.regulator_level}, 8'h02);
        uart_mode = 1'b0;
        cyc(2);
        chk({2'b00, ana}, 8'h00);
    endtask
    task automatic t_meas(input logic p, input logic [2:0] c, input logic [7:0] go, input logic [7:0] exp);
        int n;
        present  = p;
        code_sel = c;
        wr(6'h36, go);
        cyc(1);
        n        = 1;
        chk({7'h00, ana.id_meas_running}, 8'h01);
        while (rdata[3] !== 1'b1 && n < MC + 10)
        begin
            cyc(1);
            n++;
        end
        chk({7'h00, rdata[3]}, 8'h01);
        if (rdata[3] !== 1'b1)
            end_of_test();
        chk({7'h00, n >= MC - 2 && n <= MC + 2}, 8'h01);
        chk({7'h00, alt}, {7'h00, go[6]});
        rd(6'h36, exp);
        rd(6'h37, exp & 8'hF7);
        chk({7'h00, ana.id_meas_running}, 8'h00);
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        sys_rst      = 1'b1;
        req          = '0;
        uart_mode    = 1'b0;
        txen         = 1'b0;
        present      = 1'b1;
        code_sel     = 3'h0;
        error_cnt    = 0;
        total_checks = 0;
        repeat (12) @(posedge sys_clk);
        #2;
        sys_rst = 1'b0;
        t_access();
        t_levels();
        t_uart();
        t_meas(1'b1, 3'h2, 8'h10, 8'h0A);
        t_meas(1'b0, 3'h5, 8'h50, 8'h4F);
        end_of_test();
    end
endmodule
